/* File: core/ocfr_defines.vh */
// Notes on behaviour
// R1: retry code 111 restarts without limit until commanded off, bias lost or another fault.
// R2: the delay field selects two to the power of its value in time units, 1 to 128.
// R3: the length of one time unit comes from the separate time-unit register, not this byte.
// R4: the delay is the ride-through time in limit mode or the spacing between restarts.
// R5: a 16-bit read/write threshold, word access, linear format, sets the current limit.
// R6: an 8-bit read/write response byte, byte access, holds mode, retry and delay fields.
// R7: every mode sets the over-current status bit and notifies the host.
// R8: mode 00 keeps running and clamps current at the threshold forever.
// R9: mode 01 clamps while output voltage is above the low limit, else shuts down and retries.
// R10: retry code 000 never restarts; the output stays off until the fault is cleared.
// R11: retry codes 001 to 110 restart that many times, then stay off until cleared.
// R12: mode 10 clamps for the delay and, if still limiting at its end, follows the retry code.
// R13: mode 11 shuts down at once and follows the retry code.
// R14: the attempt counter restarts on a fault clear or a fresh turn-on command.
`ifndef OCFR_DEFINES_VH
`define OCFR_DEFINES_VH
`define OCFR_CMD_THRESHOLD  8'h46
`define OCFR_CMD_RESPONSE   8'h47
`define OCFR_THRESH_RST     16'h0000
`define OCFR_RESP_RST       8'h00
`define OCFR_MODE_HI        7
`define OCFR_MODE_LO        6
`define OCFR_RETRY_HI       5
`define OCFR_RETRY_LO       3
`define OCFR_DELAY_HI       2
`define OCFR_DELAY_LO       0
`define OCFR_MODE_IGNORE    2'b00
`define OCFR_MODE_COND      2'b01
`define OCFR_MODE_DELAY     2'b10
`define OCFR_MODE_DISABLE   2'b11
`define OCFR_RETRY_NONE     3'b000
`define OCFR_RETRY_FOREVER  3'b111
`define OCFR_UNITS_ONE      8'h01
`endif

/* File: core/ocfr_top.v */
`timescale 1ns/100ps
`include "ocfr_defines.vh"
module ocfr_top #(
  parameter UNIT_W = 16
) (
  input  wire              core_clk,
  input  wire              reset,
  input  wire              clk_en,
  input  wire              reg_wr,
  input  wire              reg_rd,
  input  wire [7:0]        reg_cmd,
  input  wire [15:0]       reg_wdata,
  input  wire [UNIT_W-1:0] time_unit_cycles,
  input  wire              oc_detect,
  input  wire              vout_below_lv,
  input  wire              output_on_cmd,
  input  wire              bias_ok,
  input  wire              other_fault_off,
  input  wire              fault_clear,
  output reg  [15:0]       rd_data_r,
  output reg               rd_valid_r,
  output reg               rd_err_r,
  output reg  [15:0]       oc_threshold_r,
  output reg               out_enable_r,
  output reg               cc_limit_r,
  output reg               oc_fault_bit_r,
  output reg               host_alert_r,
  output reg  [2:0]        attempts_r
);

  localparam [2:0] ST_OFF   = 3'd0;
  localparam [2:0] ST_RUN   = 3'd1;
  localparam [2:0] ST_LIMIT = 3'd2;
  localparam [2:0] ST_WAIT  = 3'd3;
  localparam [2:0] ST_LATCH = 3'd4;

  reg  [7:0]        oc_response_r;
  reg  [2:0]        state_r;
  reg  [2:0]        state_nxt;
  reg  [UNIT_W-1:0] unit_cnt_r;
  reg  [7:0]        units_left_r;
  reg               delay_load;
  reg               on_prev_r;
  reg               oc_prev_r;
  reg  [2:0]        attempts_nxt;
  reg               cc_nxt;
  reg               fault_evt;

  wire [1:0] mode     = oc_response_r[`OCFR_MODE_HI:`OCFR_MODE_LO];
  wire [2:0] retries  = oc_response_r[`OCFR_RETRY_HI:`OCFR_RETRY_LO];
  wire [2:0] dly_code = oc_response_r[`OCFR_DELAY_HI:`OCFR_DELAY_LO];
  // power of two units; shift keeps the table out of logic
  wire [7:0] dly_units = `OCFR_UNITS_ONE << dly_code; // see R2
  wire       unit_end  = (unit_cnt_r == time_unit_cycles) || (time_unit_cycles == {UNIT_W{1'b0}});
  wire       delay_done = unit_end && (units_left_r == `OCFR_UNITS_ONE);
  wire       run_ok    = output_on_cmd && bias_ok && !other_fault_off;
  wire       turn_on   = output_on_cmd && !on_prev_r;
  wire       oc_rise   = oc_detect && !oc_prev_r;

  // decision taken after a shutdown: retry again or latch off
  function [2:0] retry_state;
    input [2:0] code;
    input [2:0] done;
    begin
      if (code == `OCFR_RETRY_NONE) begin
        retry_state = ST_LATCH; // see R10
      end else if (code == `OCFR_RETRY_FOREVER) begin
        retry_state = ST_WAIT; // see R1
      end else if (done < code) begin
        retry_state = ST_WAIT; // see R11
      end else begin
        retry_state = ST_LATCH; // see R11
      end
    end
  endfunction

  always @* begin
    state_nxt    = state_r;
    attempts_nxt = attempts_r;
    delay_load   = 1'b0;
    cc_nxt       = 1'b0;
    fault_evt    = 1'b0;
    case (state_r)
      ST_OFF: begin
        if (run_ok) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (oc_rise) begin
          fault_evt = 1'b1; // see R7
        end
        if (oc_detect) begin
          case (mode)
            `OCFR_MODE_IGNORE: begin
              cc_nxt = 1'b1; // see R8
            end
            `OCFR_MODE_COND: begin
              if (vout_below_lv) begin
                state_nxt = retry_state(retries, attempts_r); // see R9
              end else begin
                cc_nxt = 1'b1; // see R9
              end
            end
            `OCFR_MODE_DELAY: begin
              cc_nxt     = 1'b1;
              state_nxt  = ST_LIMIT; // see R12
              delay_load = 1'b1; // see R4
            end
            default: begin
              state_nxt = retry_state(retries, attempts_r); // see R13
            end
          endcase
        end
      end
      ST_LIMIT: begin
        cc_nxt = oc_detect;
        if (!oc_detect) begin
          state_nxt = ST_RUN;
        end else if (delay_done) begin
          cc_nxt    = 1'b0;
          state_nxt = retry_state(retries, attempts_r); // see R12
        end
      end
      ST_WAIT: begin
        if (delay_done) begin
          state_nxt = ST_RUN; // see R4
          if (retries != `OCFR_RETRY_FOREVER) begin
            attempts_nxt = attempts_r + 3'd1; // see R11
          end
        end
      end
      ST_LATCH: begin
        if (fault_clear) begin
          state_nxt = ST_RUN; // see R10
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
    // retry delay starts fresh on entry to the wait
    if (state_r != ST_WAIT && state_nxt == ST_WAIT) begin
      delay_load = 1'b1; // see R4
    end
    if (!run_ok) begin
      state_nxt = ST_OFF; // see R1
      cc_nxt    = 1'b0;
    end
    if (fault_clear || turn_on) begin
      attempts_nxt = 3'd0; // see R14
    end
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      oc_threshold_r <= `OCFR_THRESH_RST;
      oc_response_r  <= `OCFR_RESP_RST;
      rd_data_r      <= 16'h0000;
      rd_valid_r     <= 1'b0;
      rd_err_r       <= 1'b0;
    end else if (clk_en) begin
      rd_valid_r <= reg_rd;
      rd_err_r   <= 1'b0;
      if (reg_wr && reg_cmd == `OCFR_CMD_THRESHOLD) begin
        oc_threshold_r <= reg_wdata; // see R5
      end
      if (reg_wr && reg_cmd == `OCFR_CMD_RESPONSE) begin
        oc_response_r <= reg_wdata[7:0]; // see R6
      end
      if (reg_rd) begin
        case (reg_cmd)
          `OCFR_CMD_THRESHOLD: rd_data_r <= oc_threshold_r; // see R5
          `OCFR_CMD_RESPONSE:  rd_data_r <= {8'h00, oc_response_r}; // see R6
          default: begin
            rd_data_r <= 16'h0000;
            rd_err_r  <= 1'b1;
          end
        endcase
      end
    end
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_r        <= ST_OFF;
      attempts_r     <= 3'd0;
      unit_cnt_r     <= {UNIT_W{1'b0}};
      units_left_r   <= `OCFR_UNITS_ONE;
      on_prev_r      <= 1'b0;
      oc_prev_r      <= 1'b0;
      out_enable_r   <= 1'b0;
      cc_limit_r     <= 1'b0;
      oc_fault_bit_r <= 1'b0;
      host_alert_r   <= 1'b0;
    end else if (clk_en) begin
      state_r      <= state_nxt;
      attempts_r   <= attempts_nxt;
      on_prev_r    <= output_on_cmd;
      oc_prev_r    <= oc_detect && state_r == ST_RUN;
      out_enable_r <= (state_nxt == ST_RUN) || (state_nxt == ST_LIMIT);
      cc_limit_r   <= cc_nxt;
      host_alert_r <= fault_evt; // see R7
      // set wins over a clear in the same cycle
      if (fault_evt) begin
        oc_fault_bit_r <= 1'b1; // see R7
      end else if (fault_clear) begin
        oc_fault_bit_r <= 1'b0;
      end
      // unit length comes from the external time-unit setting
      if (delay_load) begin
        unit_cnt_r   <= {UNIT_W{1'b0}};
        units_left_r <= dly_units; // see R2
      end else if (unit_end) begin
        unit_cnt_r <= {UNIT_W{1'b0}};
        if (units_left_r != `OCFR_UNITS_ONE) begin
          units_left_r <= units_left_r - 8'h01;
        end
      end else begin
        unit_cnt_r <= unit_cnt_r + {{(UNIT_W-1){1'b0}}, 1'b1}; // see R3
      end
    end
  end

endmodule // ocfr_top

/* File: tb/ocfr_monitor.sv */
`timescale 1ns/100ps
module ocfr_monitor (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        clk_en,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_cmd,
  input wire logic [15:0] reg_wdata,
  input wire logic        bias_ok,
  input wire logic        fault_clear,
  input wire logic [15:0] rd_data_r,
  input wire logic        rd_valid_r,
  input wire logic        rd_err_r,
  input wire logic [15:0] oc_threshold_r,
  input wire logic        out_enable_r,
  input wire logic        oc_fault_bit_r,
  input wire logic        host_alert_r,
  input wire logic [2:0]  attempts_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_rd_valid_pulse: assert property (clk_en && reg_rd |=> rd_valid_r) else $error("no read answer");
  a_thresh_write: assert property (clk_en && reg_wr && reg_cmd == 8'h46 |=> oc_threshold_r == $past(reg_wdata)) else $error("threshold not written");
  a_unmapped_err: assert property (clk_en && reg_rd && reg_cmd != 8'h46 && reg_cmd != 8'h47 |=> rd_err_r && rd_data_r == 16'h0000) else $error("unmapped read");
  a_resp_byte: assert property (clk_en && reg_rd && reg_cmd == 8'h47 |=> rd_data_r[15:8] == 8'h00 && !rd_err_r) else $error("response not byte");
  a_alert_sets_bit: assert property (host_alert_r |-> oc_fault_bit_r ##1 !host_alert_r) else $error("alert without bit");
  a_bit_sticky: assert property (oc_fault_bit_r && !fault_clear |=> oc_fault_bit_r) else $error("fault bit lost");
  a_clear_attempts: assert property (clk_en && fault_clear |=> attempts_r == 3'd0) else $error("attempts kept");
  a_bias_off: assert property ((clk_en && !bias_ok) [*3] |-> !out_enable_r) else $error("on without bias");
  cover property (host_alert_r);
  cover property (rd_err_r);
  cover property (attempts_r == 3'd2);
  cover property (!out_enable_r ##1 out_enable_r);
endmodule // ocfr_monitor
bind ocfr_top ocfr_monitor i_mon (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_cmd(reg_cmd), .reg_wdata(reg_wdata),
  .bias_ok(bias_ok), .fault_clear(fault_clear), .rd_data_r(rd_data_r),
  .rd_valid_r(rd_valid_r), .rd_err_r(rd_err_r), .oc_threshold_r(oc_threshold_r),
  .out_enable_r(out_enable_r), .oc_fault_bit_r(oc_fault_bit_r),
  .host_alert_r(host_alert_r), .attempts_r(attempts_r));

/* File: tb/ocfr_host.sv */
`timescale 1ns/100ps
module ocfr_host (
  input  wire logic core_clk,
  output logic      reg_wr,
  output logic      reg_rd,
  output logic [7:0]  reg_cmd,
  output logic [15:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_cmd = 8'h00;
    reg_wdata = 16'h0000;
  end
  // one-cycle strobe; answer is registered so it is seen on return
  task automatic xfer(input bit wr, input logic [7:0] cmd, input logic [15:0] d);
    @(posedge core_clk) #1;
    reg_wr = wr;
    reg_rd = !wr;
    reg_cmd = cmd;
    reg_wdata = d;
    @(posedge core_clk) #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = ~d;
  endtask
endmodule // ocfr_host

/* File: tb/tb.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t mismatch %h %h", $time, a, b); end end
module tb;
  logic core_clk = 0, reset = 1, clk_en = 1, oc_detect = 0, vout_below_lv = 0;
  logic output_on_cmd = 1, bias_ok = 1, other_fault_off = 0, fault_clear = 0;
  logic reg_wr, reg_rd, rd_valid_r, rd_err_r, out_enable_r, cc_limit_r, oc_fault_bit_r, host_alert_r;
  logic [7:0] reg_cmd;
  logic [15:0] reg_wdata, rd_data_r, oc_threshold_r, d;
  logic [2:0] attempts_r;
  logic [15:0] unit_cyc = 16'h0002;
  int n_fail = 0, tests_run = 0, cyc = 0, c;
  always #20 core_clk = ~core_clk;
  ocfr_host i_host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_cmd(reg_cmd),
    .reg_wdata(reg_wdata));
  ocfr_top #(.UNIT_W(16)) i_ocfr_top (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_cmd(reg_cmd), .reg_wdata(reg_wdata),
    .time_unit_cycles(unit_cyc), .oc_detect(oc_detect), .vout_below_lv(vout_below_lv),
    .output_on_cmd(output_on_cmd), .bias_ok(bias_ok), .other_fault_off(other_fault_off),
    .fault_clear(fault_clear), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
    .rd_err_r(rd_err_r), .oc_threshold_r(oc_threshold_r), .out_enable_r(out_enable_r),
    .cc_limit_r(cc_limit_r), .oc_fault_bit_r(oc_fault_bit_r), .host_alert_r(host_alert_r),
    .attempts_r(attempts_r));
  task automatic end_sim;
    if (n_fail == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 5000) begin
      n_fail++;
      end_sim;
    end
  end
  task automatic pulse_oc;
    @(posedge core_clk) #1 oc_detect = 1;
    @(posedge core_clk) #1 oc_detect = 0;
  endtask
  // one unit is unit_cyc+1 cycles, 2^code units per delay
  function automatic int exp_delay(input logic [2:0] code);
    return (unit_cyc + 1) << code;
  endfunction
  // counts cycles until the output comes back, bounded
  task automatic wait_on;
    for (c = 0; c < 40 && out_enable_r !== 1'b1; c++) @(posedge core_clk) #1;
  endtask
  initial begin
    void'($urandom(85));
    unit_cyc = $urandom_range(4, 1);
    repeat (5) @(posedge core_clk);
    #1 reset = 0;
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      i_host.xfer(1, 8'h46, d);
      i_host.xfer(0, 8'h46, 16'h0000);
      `CHK(rd_data_r, d)
      i_host.xfer(1, 8'h47, {~d[15:8], d[7:0]});
      i_host.xfer(0, 8'h47, 16'h0000);
      `CHK(rd_data_r, {8'h00, d[7:0]})
    end
    i_host.xfer(0, 8'h48, 16'h0000);
    `CHK(rd_err_r, 1'b1)
    i_host.xfer(1, 8'h47, 16'h0000);
    wait_on;
    @(posedge core_clk) #1 oc_detect = 1;
    repeat (3) @(posedge core_clk) #1;
    `CHK({cc_limit_r, out_enable_r, oc_fault_bit_r}, 3'b111)
    oc_detect = 0;
    @(posedge core_clk) #1 fault_clear = 1;
    @(posedge core_clk) #1 fault_clear = 0;
    i_host.xfer(1, 8'h47, 16'h00D1);
    for (int k = 1; k <= 2; k++) begin
      pulse_oc;
      `CHK({out_enable_r, oc_fault_bit_r}, 2'b01)
      wait_on;
      `CHK(c, exp_delay(3'd1))
      `CHK(attempts_r, k[2:0])
    end
    pulse_oc;
    repeat (30) @(posedge core_clk) #1;
    `CHK(out_enable_r, 1'b0)
    fault_clear = 1;
    @(posedge core_clk) #1 fault_clear = 0;
    `CHK({attempts_r, oc_fault_bit_r}, 4'h0)
    wait_on;
    bias_ok = 0;
    repeat (4) @(posedge core_clk) #1;
    `CHK(out_enable_r, 1'b0)
    bias_ok = 1;
    i_host.xfer(1, 8'h47, 16'h0040);
    wait_on;
    oc_detect = 1;
    repeat (2) @(posedge core_clk) #1;
    `CHK({cc_limit_r, out_enable_r}, 2'b11)
    vout_below_lv = 1;
    repeat (2) @(posedge core_clk) #1;
    `CHK({cc_limit_r, out_enable_r}, 2'b00)
    oc_detect = 0;
    vout_below_lv = 0;
    fault_clear = 1;
    @(posedge core_clk) #1 fault_clear = 0;
    `CHK(out_enable_r, 1'b1)
    i_host.xfer(1, 8'h47, 16'h00B8);
    oc_detect = 1;
    @(posedge core_clk) #1;
    `CHK({cc_limit_r, out_enable_r}, 2'b11)
    for (int k = 0; k < 7; k++) begin
      for (c = 0; c < 40 && out_enable_r !== 1'b0; c++) @(posedge core_clk) #1;
      wait_on;
      `CHK({out_enable_r, attempts_r}, 4'b1000)
    end
    oc_detect = 0;
    i_host.xfer(1, 8'h47, 16'h00D1);
    pulse_oc;
    wait_on;
    `CHK(attempts_r, 3'd1)
    output_on_cmd = 0;
    @(posedge core_clk) #1;
    `CHK(out_enable_r, 1'b0)
    output_on_cmd = 1;
    @(posedge core_clk) #1;
    `CHK(attempts_r, 3'd0)
    other_fault_off = 1;
    @(posedge core_clk) #1;
    `CHK(out_enable_r, 1'b0)
    other_fault_off = 0;
    end_sim;
  end
endmodule // tb
